// ===== dxi_latch.sv
// Two-pin external interrupt latch with an AHB-Lite register slave.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dxi_latch
#(
  parameter int NUM_PINS = 2
) (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  input  wire logic [NUM_PINS-1:0]  ext_int_n_i,
  input  wire logic [NUM_PINS-1:0]  vector_fetch_ack_i,
  input  wire logic                 break_active_i,
  output logic      [NUM_PINS-1:0]  cpu_irq_o,
  output logic                      wake_o
);
  import dxi_pkg::*;

  // One decode for the register map, shared by write capture and read mux
  // so the two paths can never disagree about which register is addressed.
  function automatic logic reg_hit(input logic [DXI_ADDR_W-1:0] a,
                                   input logic [31:0]           base);
    return a == base[DXI_ADDR_W-1:0];
  endfunction

  // Address phase capture.
  logic                  wr_pend_q, wr_pend_d;
  logic                  rd_pend_q, rd_pend_d;
  logic [DXI_ADDR_W-1:0] addr_q, addr_d;
  logic                  access;

  assign access = hsel_i && hready_i &&
                  (htrans_i == DXI_HTRANS_NONSEQ ||
                   htrans_i == DXI_HTRANS_SEQ);

  always_comb begin
    wr_pend_d = access && hwrite_i;
    rd_pend_d = access && !hwrite_i;
    addr_d    = access ? haddr_i[DXI_ADDR_W-1:0] : addr_q;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q    <= addr_d;
    end
  end

  // The slave never stalls: every register answers in the cycle after its
  // address phase, and read data is launched from a flop at the address edge
  // so it stands for the whole data phase.
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  logic wr_ctrl;
  logic wr_brk;
  assign wr_ctrl = wr_pend_q && reg_hit(addr_q, DXI_CTRL_ADDR);
  assign wr_brk  = wr_pend_q && reg_hit(addr_q, DXI_BRK_ADDR);

  // Control bits written by software.
  logic [NUM_PINS-1:0] sense_q, sense_d;
  logic [NUM_PINS-1:0] block_q, block_d;
  logic                brk_allow_q, brk_allow_d;
  logic [NUM_PINS-1:0] sw_clr;
  logic [NUM_PINS-1:0] wr_sense;
  logic [NUM_PINS-1:0] wr_block;
  logic [NUM_PINS-1:0] wr_clr;

  // The pin fields sit at fixed positions; these assigns and the read mux assume two.
  assign wr_sense = {hwdata_i[DXI_B_SENSE_B], hwdata_i[DXI_B_SENSE_A]};
  assign wr_block = {hwdata_i[DXI_B_BLOCK_B], hwdata_i[DXI_B_BLOCK_A]};
  assign wr_clr   = {hwdata_i[DXI_B_CLR_B],   hwdata_i[DXI_B_CLR_A]};

  always_comb begin
    sense_d     = wr_ctrl ? wr_sense : sense_q;
    block_d     = wr_ctrl ? wr_block : block_q;
    brk_allow_d = wr_brk ? hwdata_i[DXI_B_BRK_ALLOW] : brk_allow_q;
  end

  // Clear strobes only act for one cycle and are never stored.
  always_comb begin
    if (wr_ctrl && (!break_active_i || brk_allow_q)) begin
      sw_clr = wr_clr;
    end else begin
      sw_clr = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sense_q     <= '0;
      block_q     <= '0;
      brk_allow_q <= DXI_BRK_RESET;
    end else begin
      sense_q     <= sense_d;
      block_q     <= block_d;
      brk_allow_q <= brk_allow_d;
    end
  end

  // Per-pin synchroniser, edge detect and request latch.
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] last_q;
  logic [NUM_PINS-1:0] req_q;
  logic [NUM_PINS-1:0] req_d;
  logic [NUM_PINS-1:0] fall;

  // Synchronisers and the edge history reset low, so a pin that is held low
  // through reset cannot look like a fresh falling edge once reset ends; a
  // real request then needs the pin to be seen high and then low again.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      last_q  <= '0;
    end else begin
      sync1_q <= ext_int_n_i;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      assign fall[g] = last_q[g] && !sync2_q[g];

      always_comb begin
        req_d[g] = req_q[g];
        // A clear is an acknowledge; level mode holds while the pin is low.
        if (sw_clr[g] || vector_fetch_ack_i[g]) begin
          req_d[g] = req_q[g] && sense_q[g] && !sync2_q[g];
        end
        // The edge wins over a clear in the same cycle.
        if (fall[g]) begin
          req_d[g] = 1'b1;
        end
      end

      assign cpu_irq_o[g] = req_q[g] && !block_q[g];
    end
  endgenerate

  // Level-mode pending requests stay latched while the pin is low, since
  // acknowledges only drop a request once the pin has returned high.
  logic [NUM_PINS-1:0] lvl_hold_q, lvl_hold_d;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      lvl_hold_d[i] = lvl_hold_q[i];
      if (sw_clr[i] || vector_fetch_ack_i[i]) begin
        lvl_hold_d[i] = req_q[i] && sense_q[i] && !sync2_q[i];
      end
      if (fall[i]) begin
        lvl_hold_d[i] = 1'b0;
      end
      if (sync2_q[i]) begin
        lvl_hold_d[i] = 1'b0;
      end
    end
  end

  logic [NUM_PINS-1:0] req_n;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      // Acked in level mode: drop once the pin returns high.
      req_n[i] = req_d[i];
      if (lvl_hold_q[i] && sync2_q[i] && !fall[i]) begin
        req_n[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_q      <= '0;
      lvl_hold_q <= '0;
    end else begin
      req_q      <= req_n;
      lvl_hold_q <= lvl_hold_d;
    end
  end

  // Pending flags are the latched requests themselves, so with level mode
  // acknowledged on pin b the flag stays set while the pin is low and clears once it returns high.
  logic [7:0] ctrl_rd;
  always_comb begin
    ctrl_rd                = 8'h00;
    ctrl_rd[DXI_B_SENSE_A] = sense_q[0];
    ctrl_rd[DXI_B_BLOCK_A] = block_q[0];
    ctrl_rd[DXI_B_PEND_A]  = req_q[0];
    ctrl_rd[DXI_B_SENSE_B] = sense_q[1];
    ctrl_rd[DXI_B_BLOCK_B] = block_q[1];
    ctrl_rd[DXI_B_PEND_B]  = req_q[1];
  end

  logic [31:0] rdata_d, rdata_q;
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (access && !hwrite_i) begin
      if (reg_hit(haddr_i[DXI_ADDR_W-1:0], DXI_CTRL_ADDR)) begin
        rdata_d = {24'h00_0000, ctrl_rd};
      end else if (reg_hit(haddr_i[DXI_ADDR_W-1:0], DXI_BRK_ADDR)) begin
        rdata_d = {31'h0000_0000, brk_allow_q};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign hrdata_o = rdata_q;

  // The latch runs on the bus clock, so stop mode must keep that clock
  // running for pins to be seen; a fully stopped clock would miss edges.
  // Wake is a plain combinational OR so it needs no clock edge to rise
  // once a request is latched and unblocked.
  assign wake_o = |cpu_irq_o;

  // Request latch checks.
  a_edge_latches: assert property (@(posedge clk_i)
    disable iff (!rstn_i) fall[1] |=> req_q[1])
    else $error("edge did not latch");

  a_edge_latches_a: assert property (@(posedge clk_i)
    disable iff (!rstn_i) fall[0] |=> req_q[0])
    else $error("pin a edge did not latch");

  a_no_spurious_a: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (!req_q[0] && !fall[0]) |=> !req_q[0])
    else $error("pin a request set without edge");

  a_no_spurious_b: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (!req_q[1] && !fall[1]) |=> !req_q[1])
    else $error("pin b request set without edge");

  a_level_holds: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (req_q[1] && sense_q[1] && !sync2_q[1])
    |=> req_q[1]) else $error("level request dropped while low");

  a_level_holds_a: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (req_q[0] && sense_q[0] && !sync2_q[0])
    |=> req_q[0]) else $error("pin a level request dropped while low");

  a_level_drops: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (lvl_hold_q[1] && sync2_q[1] && !fall[1])
    |=> !req_q[1]) else $error("acked level request kept after pin high");

  a_vector_ack: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (vector_fetch_ack_i[1] && !sense_q[1] && !fall[1])
    |=> !req_q[1]) else $error("vector ack ignored");

  a_vector_ack_a: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (vector_fetch_ack_i[0] && !sense_q[0] && !fall[0])
    |=> !req_q[0]) else $error("pin a vector ack ignored");

  // Blocking and wake-up checks.
  a_block_gates: assert property (@(posedge clk_i)
    disable iff (!rstn_i) block_q[0] |-> !cpu_irq_o[0])
    else $error("blocked irq passed");

  a_block_gates_b: assert property (@(posedge clk_i)
    disable iff (!rstn_i) block_q[1] |-> !cpu_irq_o[1])
    else $error("blocked irq passed");

  a_wake_out: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (req_q[0] && !block_q[0]) |-> wake_o)
    else $error("no wake");

  a_wake_out_b: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (req_q[1] && !block_q[1]) |-> wake_o)
    else $error("no wake from pin b");

  // Break protection checks.
  a_break_protect: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (wr_ctrl && break_active_i && !brk_allow_q &&
    !fall[0] && !vector_fetch_ack_i[0] && !lvl_hold_q[0])
    |=> $stable(req_q[0])) else $error("break clear not blocked");

  a_break_protect_b: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (wr_ctrl && break_active_i && !brk_allow_q &&
    !fall[1] && !vector_fetch_ack_i[1] && !lvl_hold_q[1])
    |=> $stable(req_q[1])) else $error("pin b break clear not blocked");

  a_break_allow: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (wr_ctrl && hwdata_i[DXI_B_CLR_A] && brk_allow_q &&
    !sense_q[0] && !fall[0]) |=> !req_q[0])
    else $error("allowed clear failed");

  // Register read, reset and edge detect checks.
  a_flag_read_a: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (access && !hwrite_i &&
    reg_hit(haddr_i[DXI_ADDR_W-1:0], DXI_CTRL_ADDR))
    |=> (hrdata_o[DXI_B_PEND_A] == $past(req_q[0])))
    else $error("pin a flag read wrong");

  a_flag_read_b: assert property (@(posedge clk_i)
    disable iff (!rstn_i) (access && !hwrite_i &&
    reg_hit(haddr_i[DXI_ADDR_W-1:0], DXI_CTRL_ADDR))
    |=> (hrdata_o[DXI_B_PEND_B] == $past(req_q[1])))
    else $error("pin b flag read wrong");

  a_clr_reads_zero: assert property (@(posedge clk_i)
    disable iff (!rstn_i) rd_pend_q |->
    (!hrdata_o[DXI_B_CLR_A] && !hrdata_o[DXI_B_CLR_B]))
    else $error("clear strobe read back as one");

  // No disable here: this one watches the cycles just after reset ends.
  a_reset_quiet: assert property (@(posedge clk_i)
    $rose(rstn_i) |-> (req_q == '0) [*4])
    else $error("request latched straight after reset");

  a_sync_edge: assert property (@(posedge clk_i)
    disable iff (!rstn_i) fall[0] |-> ($past(sync2_q[0]) && !sync2_q[0]))
    else $error("bad edge detect");
endmodule // dxi_latch

// ===== dxi_latch_bench.sv
// Self-checking bench for the two-pin external interrupt latch.
`timescale 1ns/1ps
module dxi_latch_bench;
  import dxi_pkg::*;
  logic        clk_i;
  logic        rstn_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [1:0]  low_req;
  logic [1:0]  ext_int_n;
  logic [1:0]  vf_ack;
  logic        brk;
  logic [1:0]  cpu_irq_o;
  logic        wake_o;
  logic [31:0] rd_q;
  int          fails;
  int          checks;
  int          cyc;
  dxi_latch dxi_latch_i (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .ext_int_n_i(ext_int_n), .vector_fetch_ack_i(vf_ack),
    .break_active_i(brk), .cpu_irq_o(cpu_irq_o), .wake_o(wake_o));
  dxi_pin_src dxi_pin_src_i (.clk_i(clk_i), .low_req_i(low_req),
    .pin_n_o(ext_int_n));
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single word transfer; the address phase is held until hready.
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    hwrite_i <= w;
    hsize_i  <= 3'h2;
    htrans_i <= DXI_HTRANS_NONSEQ;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    rd_q = hrdata_o;
  endtask
  task automatic rdc(input logic [7:0] exp);
    xfer(DXI_CTRL_ADDR, 1'b0, 32'h0);
    chk(rd_q, {24'h0, exp});
  endtask
  task automatic irq(input logic [1:0] exp);
    chk({30'h0, cpu_irq_o}, {30'h0, exp});
  endtask
  // Six cycles covers the two sync stages, edge detect and latch.
  task automatic pin(input logic [1:0] lo);
    low_req <= lo;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic t_reset;
    rdc(8'h00);
    chk({31'h0, hresp_o}, 32'h0);
    xfer(DXI_BRK_ADDR, 1'b0, 32'h0);
    chk(rd_q, 32'h0);
    xfer(32'h8, 1'b1, 32'hff);
    xfer(32'h8, 1'b0, 32'h0);
    chk(rd_q, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_edge_a;
    pin(2'b01);
    irq(2'b01);
    rdc(8'h08);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h04);
    rdc(8'h00);
    irq(2'b00);
    pin(2'b00);
    $display("edge test done");
  endtask
  task automatic t_level_b;
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h30);
    pin(2'b10);
    rdc(8'hb0);
    irq(2'b00);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h70);
    rdc(8'hb0);
    pin(2'b00);
    rdc(8'h30);
    pin(2'b10);
    rdc(8'hb0);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h70);
    pin(2'b00);
    rdc(8'h30);
    pin(2'b10);
    pin(2'b00);
    rdc(8'hb0);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h70);
    rdc(8'h30);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h0);
    $display("level test done");
  endtask
  task automatic t_vector;
    pin(2'b11);
    irq(2'b11);
    chk({31'h0, wake_o}, 32'h1);
    vf_ack <= 2'b01;
    @(posedge clk_i);
    vf_ack <= 2'b10;
    @(posedge clk_i);
    vf_ack <= 2'b00;
    repeat (2) @(posedge clk_i);
    irq(2'b00);
    chk({31'h0, wake_o}, 32'h0);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h02);
    pin(2'b00);
    pin(2'b01);
    irq(2'b00);
    rdc(8'h0a);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h04);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h0);
    pin(2'b00);
    $display("vector test done");
  endtask
  task automatic t_break;
    pin(2'b01);
    brk <= 1'b1;
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h04);
    rdc(8'h08);
    xfer(DXI_BRK_ADDR, 1'b1, 32'h1);
    xfer(DXI_BRK_ADDR, 1'b0, 32'h0);
    chk(rd_q, 32'h1);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h04);
    rdc(8'h00);
    brk <= 1'b0;
    @(posedge clk_i);
    rdc(8'h00);
    xfer(DXI_BRK_ADDR, 1'b1, 32'h0);
    pin(2'b00);
    $display("break test done");
  endtask
  task automatic t_rst_low;
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h11);
    pin(2'b11);
    xfer(DXI_CTRL_ADDR, 1'b1, 32'h15);
    rdc(8'h99);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(8'h00);
    irq(2'b00);
    pin(2'b00);
    $display("reset with low pins test done");
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    rstn_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    low_req = 2'b00;
    vf_ack = 2'b00;
    brk = 1'b0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_edge_a();
    t_level_b();
    t_vector();
    t_break();
    t_rst_low();
    print_verdict();
  end
endmodule // dxi_latch_bench

// ===== dxi_pin_src.sv
// Behavioural model of the two external sources that drive the pins.
`timescale 1ns/1ps
module dxi_pin_src (
  input  wire logic       clk_i,
  input  wire logic [1:0] low_req_i,
  output logic      [1:0] pin_n_o
);
  // Both pins idle high as with a pull-up, so a source only pulls low.
  initial begin
    pin_n_o = 2'b11;
    forever @(posedge clk_i) pin_n_o <= ~low_req_i;
  end
endmodule // dxi_pin_src

// ===== dxi_pkg.sv
// Package with register layout and constants for the external interrupt latch.
package dxi_pkg;
  localparam logic [31:0] DXI_CTRL_ADDR     = 32'h0000_0000;
  localparam logic [31:0] DXI_BRK_ADDR      = 32'h0000_0004;
  localparam int          DXI_ADDR_W        = 4;
  // Bit positions in the status and control register and in the break register.
  localparam int          DXI_B_SENSE_A     = 0;
  localparam int          DXI_B_BLOCK_A     = 1;
  localparam int          DXI_B_CLR_A       = 2;
  localparam int          DXI_B_PEND_A      = 3;
  localparam int          DXI_B_SENSE_B     = 4;
  localparam int          DXI_B_BLOCK_B     = 5;
  localparam int          DXI_B_CLR_B       = 6;
  localparam int          DXI_B_PEND_B      = 7;
  localparam int          DXI_B_BRK_ALLOW   = 0;
  localparam logic [7:0]  DXI_CTRL_RESET    = 8'h00;
  localparam logic        DXI_BRK_RESET     = 1'b0;
  localparam int          DXI_SYNC_STAGES   = 2;
  localparam logic [1:0]  DXI_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  DXI_HTRANS_SEQ    = 2'h3;
endpackage : dxi_pkg
